// file: sim/stack_exec_asserts.sv
// Purpose: port-level checks of the executor
// Assumes: sees only the top ports; instruction bytes written whole
// Notes: run length is looked up from the last accepted opcode
`timescale 1ns/1ps
module stack_exec_asserts (
   input wire clk_i,
   input wire rst_i,
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [11:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   input wire [31:0] dat_o,
   input wire ack_o,
   input wire busy_o,
   input wire done_o
);
   logic [7:0] op_ff;
   logic [3:0] ncyc;
   wire wr_ack = cyc_i && stb_i && we_i && ack_o;
   wire go_w = wr_ack && sel_i[0] && adr_i[11:2] == 10'h101 && dat_i[0];
   // Instruction writes while busy are refused, so the tracker skips them
   always @(posedge clk_i) begin
      if (rst_i)
         op_ff <= 8'h00;
      else if (wr_ack && !busy_o && adr_i[11:2] == 10'h100)
         op_ff <= dat_i[23:16];
   end
   // Expected busy length, zero for an opcode outside the group
   always_comb begin
      case (op_ff)
         8'hFF, 8'h42: ncyc = 4'h4;
         8'h43, 8'h44, 8'h45, 8'h46: ncyc = 4'h6;
         8'h50, 8'h51, 8'h70, 8'h71, 8'h82, 8'h83, 8'h92, 8'h93: ncyc = 4'h8;
         default: ncyc = 4'h0;
      endcase
   end
   // ==========================================
   // Properties
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence finish;
      !busy_o && done_o;
   endsequence
   chk_run_four: assert property ($rose(busy_o) && ncyc == 4'h4 |-> busy_o [*4] ##1 finish)
      else $error("busy length wrong for four-cycle op");
   chk_run_six: assert property ($rose(busy_o) && ncyc == 4'h6 |-> busy_o [*6] ##1 finish)
      else $error("busy length wrong for six-cycle op");
   chk_run_eight: assert property ($rose(busy_o) && ncyc == 4'h8 |-> busy_o [*8] ##1 finish)
      else $error("busy length wrong for eight-cycle op");
   chk_go_starts: assert property (go_w && !busy_o && ncyc != 4'h0 |=> $rose(busy_o))
      else $error("go did not start execution");
   chk_go_refused: assert property (go_w && !busy_o && ncyc == 4'h0 |=> !busy_o ##1 !busy_o)
      else $error("invalid opcode started execution");
   chk_done_pulse: assert property (done_o |=> !done_o)
      else $error("done longer than one cycle");
   chk_done_cause: assert property (done_o |-> $past(busy_o))
      else $error("done without preceding busy");
   chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack missing one cycle after request");
   chk_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h00000000)
      else $error("read data not zero outside ack");
endmodule

// file: sim/tb.sv
// Purpose: self-checking bench of the stack and OR executor
// Assumes: registers reached over the classic bus model
// Notes: expected values worked out by hand below
`timescale 1ns/1ps
module tb;
   logic clk_i;
   logic rst_i;
   wire cyc, stb, we, ack, busy, done;
   wire [11:0] adr;
   wire [3:0] sel;
   wire [31:0] wdat, rdat;
   int error_cnt;
   int n_compared;
   stack_and_logic_op_executor u_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
      .busy_o(busy), .done_o(done));
   wb_host_model u_host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
      .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   // ==========================================
   // Tasks
   task automatic wrap_up();
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // A hung bus counts as a mismatch and ends the run
   task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
      u_host.xfer(w, a, d);
      if (u_host.tmo) begin
         error_cnt++;
         wrap_up();
      end
   endtask
   task automatic rdm(input logic [11:0] a, input logic [7:0] m, input logic [7:0] exp);
      xf(1'b0, a, 32'h00000000);
      chk(u_host.rdat[7:0] & m, exp);
   endtask
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      rdm(a, 8'hFF, exp);
   endtask
   function automatic logic [11:0] ra(input logic [7:0] i);
      return {2'h0, i, 2'h0};
   endfunction
   task automatic set(input logic [7:0] i, input logic [7:0] v);
      xf(1'b1, ra(i), {24'h000000, v});
   endtask
   task automatic start(input logic [23:0] ins, input logic [3:0] base);
      xf(1'b1, 12'h400, {8'h00, ins});
      xf(1'b1, 12'h404, {24'h000000, base, 4'h1});
   endtask
   // Counts busy cycles up to done; bounded so a stuck run is caught
   task automatic fin(input int n);
      int k, c;
      c = 0;
      for (k = 0; k < 30; k++) begin
         @(posedge clk_i);
         if (done === 1'b1)
            break;
         if (busy === 1'b1)
            c++;
      end
      if (k == 30) begin
         error_cnt++;
         wrap_up();
      end
      chk(c[7:0], n[7:0]);
   endtask
   task automatic ex(input logic [23:0] ins, input logic [3:0] base, input int n);
      start(ins, base);
      fin(n);
   endtask
   // ==========================================
   // Clock and main sequence
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   initial begin
      error_cnt = 0;
      n_compared = 0;
      rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ra(8'hD9), 8'h00);
      // Push from an empty pointer wraps to FFFF
      set(8'h40, 8'h4F);
      set(8'h4F, 8'hAA);
      ex(24'h704000, 4'h0, 8);
      rd(ra(8'hD8), 8'hFF);
      rd(ra(8'hD9), 8'hFF);
      rd(12'hBFC, 8'h4F);
      ex(24'h714000, 4'h0, 8);
      rd(ra(8'hD9), 8'hFE);
      rd(12'hBF8, 8'hAA);
      // Pops climb back through FFFF to 0000
      set(8'h01, 8'h02);
      ex(24'h500000, 4'h0, 8);
      rd(ra(8'h00), 8'hAA);
      ex(24'h510100, 4'h0, 8);
      rd(ra(8'h02), 8'h4F);
      rd(ra(8'hD8), 8'h00);
      // Stack byte written over the bus, then popped
      xf(1'b1, 12'h800, 32'h0000005A);
      ex(24'h500300, 4'h0, 8);
      rd(ra(8'h03), 8'h5A);
      rd(ra(8'hD9), 8'h01);
      // OR with C, V, D, H set beforehand
      xf(1'b1, 12'h408, 32'h0000009C);
      set(8'h00, 8'h08);
      set(8'h01, 8'h37);
      ex(24'h440100, 4'h0, 6);
      rd(ra(8'h00), 8'h3F);
      rd(ra(8'h01), 8'h37);
      rd(12'h408, 8'h8C);
      set(8'h00, 8'h08);
      set(8'h08, 8'h8A);
      ex(24'h450001, 4'h0, 6);
      rd(ra(8'h01), 8'hBF);
      rd(12'h408, 8'hAC);
      set(8'h02, 8'h00);
      ex(24'h460200, 4'h0, 6);
      rd(12'h408, 8'hCC);
      // Working registers taken from base 1
      set(8'h10, 8'h15);
      set(8'h11, 8'h2A);
      ex(24'h420100, 4'h1, 4);
      rd(ra(8'h10), 8'h3F);
      set(8'h12, 8'h01);
      ex(24'h430200, 4'h1, 6);
      rd(ra(8'h10), 8'hBF);
      // User stacks, including pointer wrap at FF
      set(8'h00, 8'h42);
      set(8'h42, 8'h6F);
      ex(24'h920002, 4'h0, 8);
      rd(ra(8'h02), 8'h6F);
      rd(ra(8'h00), 8'h41);
      set(8'h00, 8'hFF);
      set(8'hFF, 8'h70);
      ex(24'h930002, 4'h0, 8);
      rd(ra(8'h02), 8'h70);
      rd(ra(8'h00), 8'h00);
      set(8'h00, 8'h03);
      set(8'h01, 8'h05);
      ex(24'h820001, 4'h0, 8);
      rd(ra(8'h00), 8'h02);
      rd(ra(8'h02), 8'h05);
      set(8'h00, 8'h03);
      ex(24'h830001, 4'h0, 8);
      rd(ra(8'h00), 8'h04);
      rd(ra(8'h04), 8'h05);
      ex(24'hFF0000, 4'h0, 4);
      rd(12'h408, 8'hAC);
      // Write during busy is refused; it spans three of the eight busy cycles
      start(24'h704000, 4'h0);
      set(8'h04, 8'h11);
      fin(5);
      rd(ra(8'h04), 8'h05);
      // Opcode outside the group, then an unmapped place
      start(24'h000000, 4'h0);
      rdm(12'h404, 8'h03, 8'h02);
      xf(1'b1, 12'h40C, 32'h000000FF);
      rd(12'h40C, 8'h00);
      // Reset while idle clears the sticky status and the flags
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      rdm(12'h404, 8'h03, 8'h00);
      rd(12'h408, 8'h00);
      wrap_up();
   end
endmodule
bind stack_and_logic_op_executor stack_exec_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .dat_o(dat_o), .ack_o(ack_o), .busy_o(busy_o), .done_o(done_o));

// file: sim/wb_host_model.sv
// Purpose: classic Wishbone master standing in for software
// Assumes: one clock, slave answers every request with ack
// Notes: released address and data lines show inverted values, never the old ones
`timescale 1ns/1ps
module wb_host_model (
   // Clock
   input wire clk_i,
   // Slave answer
   input wire ack_i,
   input wire [31:0] dat_i,
   // Request
   output logic cyc_o,
   output logic stb_o,
   output logic we_o,
   output logic [11:0] adr_o,
   output logic [3:0] sel_o,
   output logic [31:0] dat_o
);
   bit tmo;
   logic [31:0] rdat;
   // Idle bus from time zero
   initial begin
      {cyc_o, stb_o, we_o} = 3'h0;
      adr_o = 12'h000;
      sel_o = 4'h0;
      dat_o = 32'h00000000;
      tmo = 1'b0;
   end
   // One cycle; request held until ack is sampled, then released
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clk_i);
      {cyc_o, stb_o, we_o} <= {2'h3, w};
      adr_o <= a;
      sel_o <= 4'hF;
      dat_o <= d;
      tmo = 1'b1;
      for (k = 0; k < 20; k++) begin
         @(posedge clk_i);
         if (ack_i === 1'b1) begin
            tmo = 1'b0;
            rdat = dat_i;
            break;
         end
      end
      // Toggled so a stale value can never pass for a live one
      {cyc_o, stb_o, we_o} <= 3'h0;
      adr_o <= ~a;
      dat_o <= ~d;
   endtask
endmodule

// file: src/opcode_classifier.v
// Purpose: maps an opcode of this group to class, addressing and length
// Assumes: purely combinational, opcode stable while read
// Notes: any opcode outside the group gives valid_o low
`timescale 1ns/1ps
`include "stack_exec_consts.vh"

module opcode_classifier (
   // Opcode in
   input wire [7:0] opcode_i,
   // Decoded fields
   output reg valid_o,
   output reg [2:0] cls_o,
   output reg indirect_o,
   output reg up_o,
   output reg [3:0] ncyc_o
);

   // ==========================================================
   // Decode table
   // Lengths come from a fixed table so the sequencer stays opcode-agnostic
   always @* begin
      valid_o = 1'b1;
      cls_o = `CLS_NOP;
      indirect_o = 1'b0;
      up_o = 1'b0;
      ncyc_o = `CYC_LONG;
      case (opcode_i)
         `OP_NOP: begin
            ncyc_o = `CYC_SHORT;
         end
         `OP_OR_WW: begin
            cls_o = `CLS_OR_W;
            ncyc_o = `CYC_SHORT;
         end
         `OP_OR_WI: begin
            cls_o = `CLS_OR_W;
            indirect_o = 1'b1;
            ncyc_o = `CYC_MID;
         end
         `OP_OR_RR, `OP_OR_RI: begin
            cls_o = `CLS_OR_R;
            indirect_o = opcode_i[0];
            ncyc_o = `CYC_MID;
         end
         `OP_OR_IM: begin
            cls_o = `CLS_OR_IM;
            ncyc_o = `CYC_MID;
         end
         `OP_POP_R, `OP_POP_I: begin
            cls_o = `CLS_POP;
            indirect_o = opcode_i[0];
         end
         `OP_PUSH_R, `OP_PUSH_I: begin
            cls_o = `CLS_PUSH;
            indirect_o = opcode_i[0];
         end
         `OP_UPOP_DEC, `OP_UPOP_INC: begin
            cls_o = `CLS_UPOP;
            up_o = opcode_i[0];
         end
         `OP_UPUSH_DEC, `OP_UPUSH_INC: begin
            cls_o = `CLS_UPUSH;
            up_o = opcode_i[0];
         end
         default: begin
            valid_o = 1'b0;
            ncyc_o = `CYC_SHORT;
         end
      endcase
   end

endmodule

// file: src/stack_and_logic_op_executor.v
// Purpose: executes no-op, OR, system-stack and user-stack instructions
// Assumes: software loads the instruction and starts it over classic Wishbone
// Notes: register file and stack memory live here; bus writes to them are refused while busy
//
// The Wishbone register port was chosen for this implementation.
`timescale 1ns/1ps
`include "stack_exec_consts.vh"

module stack_and_logic_op_executor (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Wishbone slave
   input wire cyc_i,
   input wire stb_i,
   input wire we_i,
   input wire [11:0] adr_i,
   input wire [3:0] sel_i,
   input wire [31:0] dat_i,
   output reg [31:0] dat_o,
   output reg ack_o,
   // Status
   output reg busy_o,
   output reg done_o
);

   // ==========================================================
   // Sequencer states
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_RES = 3'h1;
   localparam [2:0] S_MOD = 3'h2;
   localparam [2:0] S_WB = 3'h3;
   localparam [2:0] S_WAIT = 3'h4;
   // Reset value held at full width so each pointer byte is cut on purpose
   localparam [15:0] SP_INIT = `SP_RESET;

   // ==========================================================
   // Storage
   reg [7:0] rf [0:255];
   reg [7:0] stk [0:255];
   reg [7:0] stack_pointer_high_ff;
   reg [7:0] stack_pointer_low_ff;
   reg [23:0] ins_ff;
   reg [3:0] wbase_ff;
   reg [7:0] flags_ff;
   reg illegal_ff;
   reg [2:0] state_ff;
   reg [3:0] cnt_ff;
   reg [3:0] ncyc_ff;
   reg [2:0] cls_ff;
   reg ind_ff;
   reg up_ff;
   reg [7:0] src_ff;
   reg [7:0] dst_ff;
   reg [7:0] ptr_ff;
   reg [7:0] data_ff;

   // Decoder outputs
   wire dec_valid;
   wire [2:0] dec_cls;
   wire dec_ind;
   wire dec_up;
   wire [3:0] dec_ncyc;

   // Bus decode
   wire [9:0] idx = adr_i[11:2];
   wire req = cyc_i & stb_i;
   wire bus_wr = req & we_i & ack_o;
   wire [7:0] op = ins_ff[23:16];
   wire [7:0] b1 = ins_ff[15:8];
   wire [7:0] b2 = ins_ff[7:0];
   wire [15:0] sp = {stack_pointer_high_ff, stack_pointer_low_ff};
   wire go = bus_wr & (idx == `IDX_CTRL) & sel_i[0] & dat_i[`CTRL_GO] & ~busy_o;

   // ==========================================================
   // Helpers
   // Register read with the stack pointer bytes mapped in at D8 and D9
   function [7:0] rdr;
      input [7:0] a;
      begin
         if (a == `RA_SP_HIGH)
            rdr = stack_pointer_high_ff;
         else if (a == `RA_SP_LOW)
            rdr = stack_pointer_low_ff;
         else
            rdr = rf[a];
      end
   endfunction

   // Eight-bit pointer step, wraps modulo 256
   function [7:0] step8;
      input [7:0] v;
      input up;
      begin
         step8 = up ? v + 8'h01 : v - 8'h01;
      end
   endfunction

   opcode_classifier u_dec (
      .opcode_i(op),
      .valid_o(dec_valid),
      .cls_o(dec_cls),
      .indirect_o(dec_ind),
      .up_o(dec_up),
      .ncyc_o(dec_ncyc)
   );

   // ==========================================================
   // Register-file write port
   reg wr_en;
   reg [7:0] wr_a;
   reg [7:0] wr_d;
   reg sp_en;
   reg [15:0] sp_nxt;
   reg stk_we;
   reg [7:0] stk_a;
   reg [7:0] stk_d;

   // Executor owns the port while busy; bus writes only land when idle
   always @* begin
      wr_en = 1'b0;
      wr_a = 8'h00;
      wr_d = 8'h00;
      sp_en = 1'b0;
      sp_nxt = sp;
      stk_we = 1'b0;
      stk_a = 8'h00;
      stk_d = 8'h00;
      if (state_ff == S_MOD) begin
         case (cls_ff)
            `CLS_POP: begin
               sp_en = 1'b1;
               sp_nxt = sp + 16'h0001;
            end
            `CLS_PUSH: begin
               sp_en = 1'b1;
               sp_nxt = sp - 16'h0001;
            end
            `CLS_UPOP, `CLS_UPUSH: begin
               wr_en = 1'b1;
               wr_a = ptr_ff;
               wr_d = step8(rdr(ptr_ff), up_ff);
            end
            default: begin
               wr_en = 1'b0;
            end
         endcase
      end else if (state_ff == S_WB) begin
         case (cls_ff)
            `CLS_PUSH: begin
               stk_we = 1'b1;
               stk_a = stack_pointer_low_ff;
               stk_d = rdr(src_ff);
            end
            `CLS_UPUSH: begin
               wr_en = 1'b1;
               wr_a = rdr(ptr_ff);
               wr_d = data_ff;
            end
            `CLS_NOP: begin
               wr_en = 1'b0;
            end
            default: begin
               wr_en = 1'b1;
               wr_a = dst_ff;
               wr_d = data_ff;
            end
         endcase
      end else if (bus_wr & ~busy_o & sel_i[0]) begin
         if (idx[9:8] == `IDX_RF_PAGE) begin
            wr_en = 1'b1;
            wr_a = idx[7:0];
            wr_d = dat_i[7:0];
         end else if (idx[9:8] == `IDX_STK_PAGE) begin
            stk_we = 1'b1;
            stk_a = idx[7:0];
            stk_d = dat_i[7:0];
         end
      end
   end

   // ==========================================================
   // Memories, no reset on purpose: contents are data, not control
   always @(posedge clk_i) begin
      if (wr_en && wr_a != `RA_SP_HIGH && wr_a != `RA_SP_LOW)
         rf[wr_a] <= wr_d;
      if (stk_we)
         stk[stk_a] <= stk_d;
   end

   // Stack pointer bytes, also reachable as registers D8 and D9
   // Stack memory is 256 bytes, so only the low pointer byte addresses it
   always @(posedge clk_i) begin
      if (rst_i) begin
         stack_pointer_high_ff <= SP_INIT[15:8];
         stack_pointer_low_ff <= SP_INIT[7:0];
      end else if (sp_en) begin
         stack_pointer_high_ff <= sp_nxt[15:8];
         stack_pointer_low_ff <= sp_nxt[7:0];
      end else if (wr_en && wr_a == `RA_SP_HIGH) begin
         stack_pointer_high_ff <= wr_d;
      end else if (wr_en && wr_a == `RA_SP_LOW) begin
         stack_pointer_low_ff <= wr_d;
      end
   end

   // ==========================================================
   // Software-visible control, instruction and flags
   always @(posedge clk_i) begin
      if (rst_i) begin
         ins_ff <= 24'h000000;
         wbase_ff <= 4'h0;
         flags_ff <= `FLAGS_RESET;
         illegal_ff <= 1'b0;
      end else begin
         if (bus_wr && !busy_o && idx == `IDX_INSTR) begin
            if (sel_i[2])
               ins_ff[23:16] <= dat_i[23:16];
            if (sel_i[1])
               ins_ff[15:8] <= dat_i[15:8];
            if (sel_i[0])
               ins_ff[7:0] <= dat_i[7:0];
         end
         if (bus_wr && !busy_o && idx == `IDX_CTRL && sel_i[0])
            wbase_ff <= dat_i[`CTRL_WBASE_MSB:`CTRL_WBASE_LSB];
         // Unknown opcodes never start; the sticky flag tells software
         if (go)
            illegal_ff <= ~dec_valid;
         if (state_ff == S_WB && (cls_ff == `CLS_OR_W || cls_ff == `CLS_OR_R || cls_ff == `CLS_OR_IM)) begin
            flags_ff[`FLG_Z] <= (data_ff == 8'h00);
            flags_ff[`FLG_S] <= data_ff[7];
            flags_ff[`FLG_V] <= 1'b0;
         end else if (bus_wr && !busy_o && idx == `IDX_FLAGS && sel_i[0]) begin
            flags_ff <= dat_i[7:0];
         end
      end
   end

   // ==========================================================
   // Instruction sequencer
   // Work is done in the first three cycles; the rest only pads to the
   // instruction's full length so software timing loops keep their delay
   always @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= S_IDLE;
         cnt_ff <= 4'h0;
         ncyc_ff <= 4'h0;
         cls_ff <= `CLS_NOP;
         ind_ff <= 1'b0;
         up_ff <= 1'b0;
         src_ff <= 8'h00;
         dst_ff <= 8'h00;
         ptr_ff <= 8'h00;
         data_ff <= 8'h00;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         if (busy_o)
            cnt_ff <= cnt_ff + 4'h1;
         case (state_ff)
            S_IDLE: begin
               if (go && dec_valid) begin
                  state_ff <= S_RES;
                  busy_o <= 1'b1;
                  cnt_ff <= 4'h1;
                  ncyc_ff <= dec_ncyc;
                  cls_ff <= dec_cls;
                  ind_ff <= dec_ind;
                  up_ff <= dec_up;
               end
            end
            S_RES: begin
               state_ff <= S_MOD;
               case (cls_ff)
                  `CLS_OR_W: begin
                     dst_ff <= {wbase_ff, b1[7:4]};
                     src_ff <= ind_ff ? rdr({wbase_ff, b1[3:0]}) : {wbase_ff, b1[3:0]};
                  end
                  `CLS_OR_R: begin
                     src_ff <= ind_ff ? rdr(b1) : b1;
                     dst_ff <= b2;
                  end
                  `CLS_OR_IM: begin
                     dst_ff <= b1;
                     data_ff <= b2;
                  end
                  `CLS_POP: begin
                     dst_ff <= ind_ff ? rdr(b1) : b1;
                  end
                  `CLS_PUSH: begin
                     src_ff <= ind_ff ? rdr(b1) : b1;
                  end
                  `CLS_UPOP: begin
                     ptr_ff <= b1;
                     dst_ff <= b2;
                  end
                  `CLS_UPUSH: begin
                     ptr_ff <= b1;
                     src_ff <= b2;
                  end
                  default: begin
                     state_ff <= S_WAIT;
                  end
               endcase
            end
            S_MOD: begin
               state_ff <= S_WB;
               case (cls_ff)
                  `CLS_OR_W, `CLS_OR_R: begin
                     data_ff <= rdr(dst_ff) | rdr(src_ff);
                  end
                  `CLS_OR_IM: begin
                     data_ff <= rdr(dst_ff) | data_ff;
                  end
                  `CLS_POP: begin
                     data_ff <= stk[stack_pointer_low_ff];
                  end
                  `CLS_UPOP: begin
                     data_ff <= rdr(rdr(ptr_ff));
                  end
                  `CLS_UPUSH: begin
                     data_ff <= rdr(src_ff);
                  end
                  default: begin
                     data_ff <= data_ff;
                  end
               endcase
            end
            S_WB: begin
               state_ff <= S_WAIT;
            end
            S_WAIT: begin
               if (cnt_ff == ncyc_ff) begin
                  state_ff <= S_IDLE;
                  busy_o <= 1'b0;
                  done_o <= 1'b1;
                  cnt_ff <= 4'h0;
               end
            end
            default: begin
               state_ff <= S_IDLE;
               busy_o <= 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // Wishbone answer: ack one cycle after the request, dropped after one
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= req & ~ack_o;
         dat_o <= 32'h00000000;
         if (req && !ack_o && !we_i) begin
            if (idx[9:8] == `IDX_RF_PAGE)
               dat_o[7:0] <= rdr(idx[7:0]);
            else if (idx[9:8] == `IDX_STK_PAGE)
               dat_o[7:0] <= stk[idx[7:0]];
            else if (idx == `IDX_INSTR)
               dat_o[23:0] <= ins_ff;
            else if (idx == `IDX_CTRL)
               dat_o[7:0] <= {wbase_ff, 1'b0, done_o, illegal_ff, busy_o};
            else if (idx == `IDX_FLAGS)
               dat_o[7:0] <= flags_ff;
         end
      end
   end

endmodule

// file: src/stack_exec_consts.vh
// Purpose: shared constants of the stack and logic-op executor
// Assumes: included by bare name from the design files
// Notes: bus indices are word indices, byte address is four times the index
`ifndef STACK_EXEC_CONSTS_VH
`define STACK_EXEC_CONSTS_VH

// ==========================================================
// Register map (word indices)
`define IDX_SP_HIGH 10'h0D8
`define IDX_SP_LOW 10'h0D9
`define IDX_INSTR 10'h100
`define IDX_CTRL 10'h101
`define IDX_FLAGS 10'h102
`define IDX_STK_PAGE 2'h2
`define IDX_RF_PAGE 2'h0

// ==========================================================
// Register-file addresses of the stack pointer bytes
`define RA_SP_HIGH 8'hD8
`define RA_SP_LOW 8'hD9
`define SP_RESET 16'h0000

// ==========================================================
// Control register fields
`define CTRL_GO 0
`define CTRL_BUSY 0
`define CTRL_ILLEGAL 1
`define CTRL_DONE 2
`define CTRL_WBASE_LSB 4
`define CTRL_WBASE_MSB 7

// ==========================================================
// Flag bit positions
`define FLG_C 7
`define FLG_Z 6
`define FLG_S 5
`define FLG_V 4
`define FLG_D 3
`define FLG_H 2
`define FLAGS_RESET 8'h00

// ==========================================================
// Opcodes
`define OP_NOP 8'hFF
`define OP_OR_WW 8'h42
`define OP_OR_WI 8'h43
`define OP_OR_RR 8'h44
`define OP_OR_RI 8'h45
`define OP_OR_IM 8'h46
`define OP_POP_R 8'h50
`define OP_POP_I 8'h51
`define OP_PUSH_R 8'h70
`define OP_PUSH_I 8'h71
`define OP_UPUSH_DEC 8'h82
`define OP_UPUSH_INC 8'h83
`define OP_UPOP_DEC 8'h92
`define OP_UPOP_INC 8'h93

// ==========================================================
// Instruction classes
`define CLS_NOP 3'h0
`define CLS_OR_W 3'h1
`define CLS_OR_R 3'h2
`define CLS_OR_IM 3'h3
`define CLS_POP 3'h4
`define CLS_PUSH 3'h5
`define CLS_UPOP 3'h6
`define CLS_UPUSH 3'h7

// ==========================================================
// Execution lengths in core cycles
`define CYC_SHORT 4'h4
`define CYC_MID 4'h6
`define CYC_LONG 4'h8

`endif
